// [test/psmc_page_check_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "psmc_defines.svh"
module psmc_page_check_tb;
  import psmc_pkg::*;
  typedef struct packed {logic err; logic [31:0] mask; logic [31:0] val;} psmc_note_s;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        restore, reject, ready, clash;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [2:0]  perm;
  logic [15:0] n_rs, n_rj, n_rd;
  psmc_note_s  rd_q[$], vd_q[$], nt;
  int          fail_count, n_tests, cyc, e_rs, e_rj, e_rd;
  logic [31:0] rec [32];
  logic [31:0] refw [4];

  psmc_page_check i_psmc_page_check (.CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PAGE_RESTORE(restore), .PAGE_REJECT(reject),
    .RECORD_READY(ready), .PAGE_PERM(perm));
  psmc_seq_model i_psmc_seq_model (.clk(clk), .rst(rst), .restore(restore), .reject(reject),
    .ready(ready), .n_restore(n_rs), .n_reject(n_rj), .n_ready(n_rd), .clash(clash));

  // ----------------------------------------
  // Clock, timeout, helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task end_sim();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Generous ceiling; a full run needs under two thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  // Monitor: oldest note against each completed transfer or verdict pulse
  always @(posedge clk) begin
    if (psel && penable && pready) begin
      if (rd_q.size() == 0) chk("spare apb", 32'h0, 32'h1);
      else begin
        nt = rd_q.pop_front();
        chk("pslverr", {31'h0, nt.err}, {31'h0, pslverr});
        chk("prdata", nt.val & nt.mask, prdata & nt.mask);
      end
    end
    if (restore || reject || ready) begin
      if (vd_q.size() == 0) chk("spare verdict", 32'h0, 32'h1);
      else begin
        nt = vd_q.pop_front();
        chk("verdict", nt.val & nt.mask, {26'h0, perm, restore, reject, ready} & nt.mask);
      end
    end
  end

  // ----------------------------------------
  // Bus and operation tasks
  // ----------------------------------------
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
           input logic e, input logic [31:0] m, input logic [31:0] x);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    rd_q.push_back('{err: e, mask: (w ? 32'h0 : m), val: x});
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf, 1'b0, 32'h0, 32'h0);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0, 4'hf, 1'b0, m, x);
  endtask
  task fresh(input logic [7:0] k);
    foreach (rec[i]) rec[i] = 32'h0;
    rec[0]  = {16'h0, k, 2'b00, 6'($urandom)};
    rec[16] = $urandom;
    rec[17] = $urandom;
    for (int i = 0; i < 4; i++) begin
      rec[28+i] = $urandom;
      refw[i]   = rec[28+i];
    end
  endtask
  task load();
    for (int i = 0; i < 32; i++) wr(12'(i*4), rec[i]);
    for (int i = 0; i < 4; i++) wr(`PSMC_OFF_MACREF0 + 12'(i*4), refw[i]);
  endtask
  // Verdict lands two edges after the start; perm checked on restores
  task start(input psmc_op_e op, input logic cap, input logic [2:0] v);
    wr(`PSMC_OFF_CTRL, {28'h0, cap, op, 1'b1});
    if (v != 3'h0) vd_q.push_back('{err: 1'b0, mask: (v[2] ? 32'h3f : 32'h7),
                                    val: {26'h0, rec[0][2:0], v}});
    e_rs += v[2];
    e_rj += v[1];
    e_rd += v[0];
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [31:0] est(input logic cap, input logic mal, input logic mac);
    logic [7:0] k;
    logic       rs;
    logic       rj;
    k  = rec[0][15:8];
    rs = (k > 8'h6) || (k > 8'h4 && !cap);
    rj = rs | mal | mac;
    return {9'h0, (rs ? 3'h7 : k[2:0]), k, rec[0][5:3], rec[0][2:0], mac, rs, mal | rs, rj, !rj,
            1'b1};
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {fail_count, n_tests, cyc, e_rs, e_rj, e_rd} = '0;
    rst = 1'b1;
    void'($urandom(32'hd267ffb3));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(`PSMC_OFF_STATUS, 32'hffffffff, 32'h0);
    $display("test reset done");
    fresh(8'h0);
    load();
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 10; k++) begin
        rec[0][15:8] = (k == 9) ? 8'hff : 8'(k);
        wr(12'h000, rec[0]);
        start(PSMC_OP_ATTR, c[0], 3'h0);
        rd(`PSMC_OFF_STATUS, 32'h7fffff, est(c[0], 1'b0, 1'b0));
      end
    end
    rd(`PSMC_OFF_CTRL, 32'hf, {28'h0, 1'b1, PSMC_OP_ATTR, 1'b0});
    $display("test kinds done");
    for (int i = 0; i < 4; i++) begin
      fresh(8'($urandom_range(4)));
      load();
      start(PSMC_OP_RELOAD, 1'b0, 3'h4);
      rd(`PSMC_OFF_STATUS, 32'h7fffff, est(1'b0, 1'b0, 1'b0));
    end
    $display("test reload done");
    for (int j = 0; j < 7; j++) begin
      fresh(8'h2);
      case (j)
        0: rec[0][6] = 1'b1;
        1: rec[0][7] = 1'b1;
        2: rec[0][16 + $urandom_range(15)] = 1'b1;
        3: rec[1][$urandom_range(31)] = 1'b1;
        4: rec[2 + $urandom_range(13)] = 32'h1 << $urandom_range(31);
        5: rec[18 + $urandom_range(9)] = 32'h1 << $urandom_range(31);
        default: rec[28 + $urandom_range(3)] ^= 32'h1 << $urandom_range(31);
      endcase
      load();
      start(PSMC_OP_RELOAD, 1'b0, 3'h2);
      rd(`PSMC_OFF_STATUS, 32'h7 | (j < 4 ? 32'h8 : 32'h0) | (j == 6 ? 32'h20 : 32'h0),
         est(1'b0, j < 6, j == 6));
    end
    $display("test reject done");
    fresh(8'h2);
    for (int i = 18; i < 28; i++) rec[i] = $urandom | 32'h1;
    for (int i = 0; i < 4; i++) refw[i] = $urandom;
    load();
    start(PSMC_OP_EVICT, 1'b0, 3'h1);
    for (int i = 0; i < 4; i++) rec[28+i] = refw[i];
    for (int i = 18; i < 28; i++) rec[i] = 32'h0;
    for (int i = 16; i < 32; i++) rd(12'(i*4), 32'hffffffff, rec[i]);
    start(PSMC_OP_RELOAD, 1'b0, 3'h4);
    rec[0][7] = 1'b1;
    wr(12'h000, rec[0]);
    wr(`PSMC_OFF_MACREF0, ~refw[0]);
    start(PSMC_OP_EVICT, 1'b0, 3'h2);
    rd(12'h070, 32'hffffffff, rec[28]);
    rd(`PSMC_OFF_MACREF3, 32'hffffffff, refw[3]);
    $display("test evict done");
    apb(1'b0, 12'h098, 32'h0, 4'hf, 1'b1, 32'hffffffff, 32'h0);
    apb(1'b1, `PSMC_OFF_STATUS, 32'h1, 4'hf, 1'b1, 32'h0, 32'h0);
    wr(12'h040, 32'hffffffff);
    apb(1'b1, 12'h040, 32'h0, 4'b0101, 1'b0, 32'h0, 32'h0);
    rd(12'h040, 32'hffffffff, 32'hff00ff00);
    $display("test bus done");
    repeat (4) @(posedge clk);
    chk("notes left", 32'h0, 32'(rd_q.size() + vd_q.size()));
    chk("restores", 32'(e_rs), {16'h0, n_rs});
    chk("rejects", 32'(e_rj), {16'h0, n_rj});
    chk("sealed", 32'(e_rd), {16'h0, n_rd});
    chk("clash", 32'h0, {31'h0, clash});
    end_sim();
  end
endmodule // psmc_page_check_tb
`default_nettype wire

// [test/psmc_seq_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Page sequencer model: consumes verdicts
// ----------------------------------------
module psmc_seq_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Verdicts from the checker
  input  wire logic        restore,
  input  wire logic        reject,
  input  wire logic        ready,
  // Tallies for the bench
  output logic      [15:0] n_restore,
  output logic      [15:0] n_reject,
  output logic      [15:0] n_ready,
  output logic             clash
);
  // Counts each verdict pulse by kind; two verdicts at once is a clash
  always_ff @(posedge clk) begin
    if (rst) begin
      n_restore <= 16'h0;
      n_reject  <= 16'h0;
      n_ready   <= 16'h0;
      clash     <= 1'b0;
    end else begin
      n_restore <= n_restore + {15'h0, restore};
      n_reject  <= n_reject + {15'h0, reject};
      n_ready   <= n_ready + {15'h0, ready};
      if ({1'b0, restore} + {1'b0, reject} + {1'b0, ready} > 2'h1) clash <= 1'b1;
    end
  end
endmodule // psmc_seq_model
`default_nettype wire

// [verilog/psmc_defines.svh]
`ifndef PSMC_DEFINES_SVH
`define PSMC_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets, record size and reset values
// ----------------------------------------------------------------
`define PSMC_OFF_CTRL     12'h080
`define PSMC_OFF_STATUS   12'h084
`define PSMC_OFF_MACREF0  12'h088
`define PSMC_OFF_MACREF3  12'h094
`define PSMC_REC_WORDS    32
`define PSMC_RST_WORD     32'h0000_0000
`define PSMC_RST_OP       2'h0

// ----------------------------------------------------------------
// Record word indices (32-bit words, little endian)
// ----------------------------------------------------------------
`define PSMC_W_ATTR_RSV_LO  2
`define PSMC_W_ATTR_RSV_HI  15
`define PSMC_W_TAG_LO       16
`define PSMC_W_META_RSV_LO  18
`define PSMC_W_META_RSV_HI  27
`define PSMC_W_MAC_LO       28
`define PSMC_W_MAC_HI       31

// ----------------------------------------------------------------
// Flags word bit positions
// ----------------------------------------------------------------
`define PSMC_FLG_READ    0
`define PSMC_FLG_WRITE   1
`define PSMC_FLG_EXEC    2
`define PSMC_FLG_AWAIT   3
`define PSMC_FLG_ALTER   4
`define PSMC_FLG_NARROW  5
`define PSMC_FLG_RSV_LO  6
`define PSMC_FLG_RSV_HI  7
`define PSMC_FLG_KIND_LO 8
`define PSMC_FLG_KIND_HI 15
`define PSMC_FLG_RSV2_LO 16

// ----------------------------------------------------------------
// Control and status bit positions
// ----------------------------------------------------------------
`define PSMC_CTL_START   0
`define PSMC_CTL_OP_LO   1
`define PSMC_CTL_OP_HI   2
`define PSMC_CTL_SSCAP   3
`define PSMC_ST_DONE     0
`define PSMC_ST_ACCEPT   1
`define PSMC_ST_REJECT   2
`define PSMC_ST_MALFORM  3
`define PSMC_ST_KINDRSV  4
`define PSMC_ST_MACBAD   5
`define PSMC_ST_PERM_LO  6
`define PSMC_ST_AWAIT    9
`define PSMC_ST_ALTER    10
`define PSMC_ST_NARROW   11
`define PSMC_ST_KIND_LO  12
`define PSMC_ST_KIND_HI  19
`define PSMC_ST_DEC_LO   20
`define PSMC_ST_DEC_HI   22

`endif

// [verilog/psmc_page_check.sv]
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "psmc_defines.svh"

module psmc_page_check
  import psmc_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Verdicts toward the page sequencer
  output logic             PAGE_RESTORE,
  output logic             PAGE_REJECT,
  output logic             RECORD_READY,
  output logic      [2:0]  PAGE_PERM
);

  // ----------------------------------------------------------------
  // State and field views
  // ----------------------------------------------------------------
  psmc_state_s s_reg;
  psmc_state_s s_next;

  logic [63:0]  flags;
  logic [7:0]   kind_code;
  psmc_kind_e   kind_dec;
  logic         flag_rsv_bad;
  logic         attr_rsv_bad;
  logic         meta_rsv_bad;
  logic         mac_bad;
  logic         malformed;
  logic         wr_acc;
  logic         rd_setup;
  logic [9:0]   word_addr;
  logic         hit_rec;
  logic         hit_ctrl;
  logic         hit_status;
  logic         hit_ref;
  logic [1:0]   ref_idx;

  // Byte-lane merge for APB4 strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Record decode, purely combinational on the buffer
  // ----------------------------------------------------------------
  assign flags        = {s_reg.rec[1], s_reg.rec[0]};
  assign kind_code    = flags[`PSMC_FLG_KIND_HI:`PSMC_FLG_KIND_LO];
  assign flag_rsv_bad = (|flags[`PSMC_FLG_RSV_HI:`PSMC_FLG_RSV_LO])
                      | (|flags[63:`PSMC_FLG_RSV2_LO]);
  // Bytes 8..63 of the attribute block must be zero
  assign attr_rsv_bad = |s_reg.rec[`PSMC_W_ATTR_RSV_HI:`PSMC_W_ATTR_RSV_LO];
  // Bytes 72..111 of the record must be zero
  assign meta_rsv_bad = |s_reg.rec[`PSMC_W_META_RSV_HI:`PSMC_W_META_RSV_LO];
  // Code itself comes from the crypto engine; here it is compared, and on eviction copied into the record
  assign mac_bad      = s_reg.rec[`PSMC_W_MAC_HI:`PSMC_W_MAC_LO] != s_reg.mac_ref;
  assign malformed    = flag_rsv_bad | attr_rsv_bad | (kind_dec == PSMC_KIND_RSV);

  // Kind decoder; shadow-stack codes depend on the capability bit
  always_comb begin
    case (kind_code)
      8'h00:   kind_dec = PSMC_KIND_CONTROL;
      8'h01:   kind_dec = PSMC_KIND_THREAD;
      8'h02:   kind_dec = PSMC_KIND_ORDINARY;
      8'h03:   kind_dec = PSMC_KIND_VERSION;
      8'h04:   kind_dec = PSMC_KIND_CUTBACK;
      8'h05:   kind_dec = s_reg.ss_cap ? PSMC_KIND_SS_HEAD : PSMC_KIND_RSV;
      8'h06:   kind_dec = s_reg.ss_cap ? PSMC_KIND_SS_TAIL : PSMC_KIND_RSV;
      default: kind_dec = PSMC_KIND_RSV;
    endcase
  end

  // APB phases; zero wait states
  assign wr_acc   = PSEL & PENABLE & PWRITE;
  assign rd_setup = PSEL & ~PENABLE;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Word index; the two low address bits are ignored
  assign word_addr  = PADDR[11:2];
  assign hit_rec    = PADDR[11:7] == 5'h00;
  assign hit_ctrl   = word_addr == 10'(`PSMC_OFF_CTRL >> 2);
  assign hit_status = word_addr == 10'(`PSMC_OFF_STATUS >> 2);
  assign hit_ref    = (word_addr >= 10'(`PSMC_OFF_MACREF0 >> 2))
                    && (word_addr <= 10'(`PSMC_OFF_MACREF3 >> 2));
  // Kept at two bits so the reference slot index can never leave its range
  assign ref_idx    = 2'(word_addr - 10'(`PSMC_OFF_MACREF0 >> 2));

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next         = s_reg;
    s_next.restore = 1'b0;
    s_next.reject  = 1'b0;
    s_next.ready   = 1'b0;

    // One-cycle check; verdict and decoded flags land in status
    case (s_reg.st)
      PSMC_CHECK: begin
        s_next.st = PSMC_IDLE;
        s_next.status[`PSMC_ST_DONE]    = 1'b1;
        s_next.status[`PSMC_ST_PERM_LO] = flags[`PSMC_FLG_READ];
        s_next.status[`PSMC_ST_PERM_LO + 1] = flags[`PSMC_FLG_WRITE];
        s_next.status[`PSMC_ST_PERM_LO + 2] = flags[`PSMC_FLG_EXEC];
        s_next.status[`PSMC_ST_AWAIT]   = flags[`PSMC_FLG_AWAIT];
        s_next.status[`PSMC_ST_ALTER]   = flags[`PSMC_FLG_ALTER];
        s_next.status[`PSMC_ST_NARROW]  = flags[`PSMC_FLG_NARROW];
        s_next.status[`PSMC_ST_KIND_HI:`PSMC_ST_KIND_LO] = kind_code;
        s_next.status[`PSMC_ST_DEC_HI:`PSMC_ST_DEC_LO]   = kind_dec;
        s_next.status[`PSMC_ST_KINDRSV] = kind_dec == PSMC_KIND_RSV;
        s_next.status[`PSMC_ST_MALFORM] = malformed;
        s_next.status[`PSMC_ST_MACBAD]  = mac_bad;
        case (s_reg.op)
          PSMC_OP_RELOAD: begin
            // Nothing is restored unless every field checks out
            if (malformed | meta_rsv_bad | mac_bad) begin
              s_next.reject = 1'b1;
              s_next.status[`PSMC_ST_REJECT] = 1'b1;
            end else begin
              s_next.restore = 1'b1;
              s_next.status[`PSMC_ST_ACCEPT] = 1'b1;
            end
          end
          PSMC_OP_EVICT: begin
            // Refuse to seal a malformed attribute copy
            if (malformed) begin
              s_next.reject = 1'b1;
              s_next.status[`PSMC_ST_REJECT] = 1'b1;
            end else begin
              for (int w = `PSMC_W_META_RSV_LO; w <= `PSMC_W_META_RSV_HI; w++) begin
                s_next.rec[w] = `PSMC_RST_WORD;
              end
              s_next.rec[`PSMC_W_MAC_HI:`PSMC_W_MAC_LO] = s_reg.mac_ref;
              s_next.ready = 1'b1;
              s_next.status[`PSMC_ST_ACCEPT] = 1'b1;
            end
          end
          default: begin
            s_next.status[`PSMC_ST_ACCEPT] = ~malformed;
            s_next.status[`PSMC_ST_REJECT] = malformed;
          end
        endcase
      end
      default: begin
        s_next.st = PSMC_IDLE;
      end
    endcase

    // Bus writes; the record window is exactly 32 words, no more
    if (wr_acc) begin
      if (hit_rec) begin
        s_next.rec[PADDR[6:2]] = merge(s_reg.rec[PADDR[6:2]], PWDATA, PSTRB);
      end else if (hit_ctrl) begin
        s_next.op     = psmc_op_e'(PWDATA[`PSMC_CTL_OP_HI:`PSMC_CTL_OP_LO]);
        s_next.ss_cap = PWDATA[`PSMC_CTL_SSCAP];
        if (PWDATA[`PSMC_CTL_START]) begin
          s_next.st     = PSMC_CHECK;
          s_next.status = `PSMC_RST_WORD;
        end
      end else if (hit_ref) begin
        s_next.mac_ref[32*ref_idx +: 32] =
          merge(s_reg.mac_ref[32*ref_idx +: 32], PWDATA, PSTRB);
      end
    end

    // Read data captured in the setup phase; unmapped gives an error
    if (rd_setup) begin
      s_next.prdata  = `PSMC_RST_WORD;
      s_next.pslverr = 1'b0;
      if (hit_rec) begin
        s_next.prdata = PWRITE ? `PSMC_RST_WORD : s_reg.rec[PADDR[6:2]];
      end else if (hit_ctrl) begin
        s_next.prdata = {28'h0, s_reg.ss_cap, s_reg.op, 1'b0};
      end else if (hit_status) begin
        s_next.prdata  = s_reg.status;
        s_next.pslverr = PWRITE;
      end else if (hit_ref) begin
        s_next.prdata = s_reg.mac_ref[32*ref_idx +: 32];
      end else begin
        s_next.pslverr = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s_reg    <= '0;
      s_reg.st <= PSMC_IDLE;
      s_reg.op <= psmc_op_e'(`PSMC_RST_OP);
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign PRDATA       = s_reg.prdata;
  assign PSLVERR      = s_reg.pslverr & PSEL & PENABLE;
  assign PREADY       = PSEL & PENABLE;
  assign PAGE_RESTORE = s_reg.restore;
  assign PAGE_REJECT  = s_reg.reject;
  assign RECORD_READY = s_reg.ready;
  assign PAGE_PERM    = s_reg.status[`PSMC_ST_PERM_LO +: 3];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  logic chk;
  assign chk = s_reg.st == PSMC_CHECK;

  chk_attr_rsv_rej: assert property (chk && attr_rsv_bad && s_reg.op != PSMC_OP_ATTR
    |=> PAGE_REJECT) else $error("reserved attribute bytes not rejected");
  chk_perm_read: assert property (chk |=> PAGE_PERM[0] == $past(s_reg.rec[0][0]))
    else $error("read permission wrong");
  chk_perm_write: assert property (chk |=> PAGE_PERM[1] == $past(s_reg.rec[0][1]))
    else $error("write permission wrong");
  chk_perm_exec: assert property (chk ##1 !chk[*2] |-> PAGE_PERM[2] == $past(s_reg.rec[0][2], 2))
    else $error("exec permission wrong");
  chk_state_await: assert property (chk |=> s_reg.status[`PSMC_ST_AWAIT] == $past(flags[3]))
    else $error("await state wrong");
  chk_state_alter: assert property (chk |=> s_reg.status[`PSMC_ST_ALTER] == $past(flags[4]))
    else $error("altered state wrong");
  chk_state_narrow: assert property (chk |=> s_reg.status[`PSMC_ST_NARROW] == $past(flags[5]))
    else $error("narrowing flag wrong");
  chk_flag_rsv: assert property (chk && |s_reg.rec[0][7:6] |=> s_reg.status[`PSMC_ST_MALFORM])
    else $error("reserved flag bits missed");
  chk_kind_field: assert property (chk |=> s_reg.status[19:12] == $past(s_reg.rec[0][15:8]))
    else $error("kind field wrong");
  chk_kind_ord: assert property (chk && kind_code == 8'h02 |=>
    s_reg.status[22:20] == PSMC_KIND_ORDINARY) else $error("ordinary kind wrong");
  chk_kind_ss: assert property (chk && s_reg.ss_cap && kind_code == 8'h05 |=>
    s_reg.status[22:20] == PSMC_KIND_SS_HEAD) else $error("stack head kind wrong");
  chk_kind_rsv: assert property (chk && kind_code > 8'h06 |=>
    s_reg.status[`PSMC_ST_KINDRSV]) else $error("reserved kind accepted");
  chk_meta_rsv: assert property (chk && s_reg.op == PSMC_OP_RELOAD && meta_rsv_bad
    |=> PAGE_REJECT && !PAGE_RESTORE) else $error("reserved record bytes accepted");
  chk_evict_mac: assert property (chk && s_reg.op == PSMC_OP_EVICT && !malformed
    |=> RECORD_READY && s_reg.rec[31:28] == $past(s_reg.mac_ref))
    else $error("evicted record not sealed");
  chk_reload_verdict: assert property (wr_acc && PADDR == `PSMC_OFF_CTRL && PWDATA[0]
    && PWDATA[2:1] == 2'h1 |=> ##1 (PAGE_RESTORE ^ PAGE_REJECT))
    else $error("reload gave no verdict");
  chk_restore_clean: assert property (PAGE_RESTORE |-> !$past(mac_bad) && !$past(malformed)
    && !$past(meta_rsv_bad)) else $error("page restored despite failure");
  chk_flag_hi: assert property (chk && |s_reg.rec[1] |=> s_reg.status[`PSMC_ST_MALFORM])
    else $error("upper reserved flag bits missed");
  chk_attr_flag: assert property (chk && attr_rsv_bad |=> s_reg.status[`PSMC_ST_MALFORM])
    else $error("reserved attribute bytes not flagged");

  // Decode of the remaining kind codes
  chk_kind_low: assert property (chk && kind_code < 8'h05 |=>
    s_reg.status[22:20] == $past(kind_code[2:0])) else $error("low kind code wrong");
  chk_kind_tail: assert property (chk && s_reg.ss_cap && kind_code == 8'h06 |=>
    s_reg.status[22:20] == PSMC_KIND_SS_TAIL) else $error("stack tail kind wrong");
  chk_ss_nocap: assert property (chk && !s_reg.ss_cap
    && (kind_code == 8'h05 || kind_code == 8'h06) |=> s_reg.status[22:20] == PSMC_KIND_RSV)
    else $error("stack kind without capability");

  // Record handling on eviction, then the code and done flags; a refused seal must leave the record alone
  chk_evict_zero: assert property (chk && s_reg.op == PSMC_OP_EVICT && !malformed
    |=> !(|s_reg.rec[`PSMC_W_META_RSV_HI:`PSMC_W_META_RSV_LO]))
    else $error("reserved record words not cleared");
  chk_evict_keep: assert property (chk && s_reg.op == PSMC_OP_EVICT && malformed
    |=> PAGE_REJECT && !RECORD_READY && $stable(s_reg.rec))
    else $error("malformed record sealed");
  chk_mac_flag: assert property (chk && mac_bad |=> s_reg.status[`PSMC_ST_MACBAD])
    else $error("code mismatch not reported");
  chk_done_flag: assert property (chk |=> s_reg.status[`PSMC_ST_DONE])
    else $error("check not marked done");

  // Verdicts and bus errors
  chk_verdict_excl: assert property (!(PAGE_RESTORE && PAGE_REJECT))
    else $error("restore and reject together");
  chk_reload_mac: assert property (chk && s_reg.op == PSMC_OP_RELOAD && mac_bad
    |=> PAGE_REJECT && !PAGE_RESTORE) else $error("bad code not rejected");
  chk_attr_quiet: assert property (chk && s_reg.op == PSMC_OP_ATTR
    |=> !PAGE_RESTORE && !PAGE_REJECT && !RECORD_READY) else $error("attribute check pulsed");
  chk_bus_unmapped: assert property (PSEL && PENABLE && !hit_rec && !hit_ctrl
    && !hit_status && !hit_ref |-> PSLVERR) else $error("unmapped access not refused");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  cov_restore: cover property (PAGE_RESTORE);
  cov_reject:  cover property (PAGE_REJECT && s_reg.status[`PSMC_ST_MACBAD]);
  cov_evict:   cover property (RECORD_READY);
  cov_malform: cover property (PAGE_REJECT && s_reg.status[`PSMC_ST_MALFORM]);
  cov_ss_tail: cover property (chk && s_reg.ss_cap && kind_code == 8'h06);

endmodule // psmc_page_check

`default_nettype wire

// [verilog/psmc_pkg.sv]
package psmc_pkg;

  // Operation requested through the control register
  typedef enum logic [1:0] {
    PSMC_OP_ATTR   = 2'h0,
    PSMC_OP_RELOAD = 2'h1,
    PSMC_OP_EVICT  = 2'h2
  } psmc_op_e;

  // Checker states, Gray coded
  typedef enum logic [1:0] {
    PSMC_IDLE  = 2'h0,
    PSMC_CHECK = 2'h1
  } psmc_st_e;

  // Decoded page kind; 7 marks a reserved code
  typedef enum logic [2:0] {
    PSMC_KIND_CONTROL  = 3'h0,
    PSMC_KIND_THREAD   = 3'h1,
    PSMC_KIND_ORDINARY = 3'h2,
    PSMC_KIND_VERSION  = 3'h3,
    PSMC_KIND_CUTBACK  = 3'h4,
    PSMC_KIND_SS_HEAD  = 3'h5,
    PSMC_KIND_SS_TAIL  = 3'h6,
    PSMC_KIND_RSV      = 3'h7
  } psmc_kind_e;

  // Whole state of the checker
  typedef struct packed {
    psmc_st_e          st;
    logic [31:0][31:0] rec;
    logic [127:0]      mac_ref;
    psmc_op_e          op;
    logic              ss_cap;
    logic [31:0]       status;
    logic              restore;
    logic              reject;
    logic              ready;
    logic [31:0]       prdata;
    logic              pslverr;
  } psmc_state_s;

endpackage
